// File: logic/boot_pkg.sv
// constants and types shared by the serial boot loader
//
// Functional notes
// - host opens with a zero byte; device answers with its identification byte
// - after the identification byte the device takes 32 code bytes
// - on a shared wire the sent identification byte counts as code byte zero
// - identification start bit begins inside the host's zero-byte stop bit
package boot_pkg;

   // ==========================================================
   // timing
   localparam int CLK_HZ     = 125_000_000; // system clock rate
   localparam int BAUD_RATE  = 9600;        // serial rate in bit/s
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE; // clocks per bit

   // ==========================================================
   // protocol values
   localparam int        CODE_BYTES = 32;    // length of the code block
   localparam logic [7:0] OPEN_BYTE = 8'h00; // byte that opens the exchange
   localparam logic [7:0] ID_BYTE   = 8'h5a; // arbitrary identification value
   localparam logic [4:0] FIRST_IDX = 5'h00; // start of the code buffer
   localparam logic [4:0] LAST_IDX  = 5'h1f; // last index of the block

   // ==========================================================
   // reset values
   localparam logic       LINE_IDLE = 1'b1;  // idle level of the serial line
   localparam logic [5:0] CNT_ZERO  = 6'h00; // byte counters after reset

   // ==========================================================
   // state encodings
   typedef enum logic [1:0] {
      LD_WAIT = 2'b00, // waiting for the opening byte
      LD_ID   = 2'b01, // sending the identification byte
      LD_LOAD = 2'b10, // collecting code bytes
      LD_RUN  = 2'b11  // block handed over, executing
   } ld_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

endpackage

// File: logic/pair_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module pair_fifo #(
   parameter int WIDTH = 13, // word width
   parameter int DEPTH = 2   // number of entries
) (
   input  wire logic             clk,       // system clock
   input  wire logic             rst,       // synchronous reset
   input  wire logic             in_valid,  // writer offers a word
   output      logic             in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] in_data,   // word to store
   output      logic             out_valid, // a word is waiting
   input  wire logic             out_ready, // reader takes the word
   output      logic [WIDTH-1:0] out_data   // oldest word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (count_reg != CNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // ==========================================================
   // storage, written by index
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // pointers wrap at the last entry so any depth works
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   // occupancy: simultaneous push and pop leave it unchanged
   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule // pair_fifo

// File: logic/boot_loader.sv
// serial bootstrap loader: handshake, code block reception, hand-over
`timescale 1ns/1ns
module boot_loader
   import boot_pkg::*;
#(
   parameter int BIT_CYCLES_P = BIT_CYCLES // clocks per serial bit
) (
   input  wire logic       clk,         // system clock, 125 MHz
   input  wire logic       rst,         // synchronous reset, active high
   input  wire logic       rx_pin,      // serial receive line
   output      logic       tx_out,      // serial transmit line
   input  wire logic       single_wire, // receive and transmit share a wire
   output      logic       code_valid,  // code byte offered
   input  wire logic       code_ready,  // program store takes the byte
   output      logic [7:0] code_data,   // code byte
   output      logic [4:0] code_index,  // position in the code block
   output      logic       exec_start,  // pulse: run from code index 0
   output      logic       loading,     // exchange in progress
   output      logic       overrun      // a byte was lost to a full buffer
);
   localparam int TW = $clog2(BIT_CYCLES_P + 1);
   localparam logic [TW-1:0] BIT_LAST  = TW'(BIT_CYCLES_P - 1);
   localparam logic [TW-1:0] HALF_LAST = TW'(BIT_CYCLES_P / 2 - 1);
   localparam logic [5:0]    BLOCK_LEN = 6'(CODE_BYTES);

   // ==========================================================
   // receive line synchroniser
   logic [2:0] sync_reg;
   logic       rx_level_reg;

   // the first stage feeds only the second; a change counts once
   // the second and third stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_reg <= {3{LINE_IDLE}};
      end else begin
         sync_reg <= {sync_reg[1:0], rx_pin};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_level_reg <= LINE_IDLE;
      end else if (sync_reg[1] == sync_reg[2]) begin
         rx_level_reg <= sync_reg[2];
      end
   end

   // ==========================================================
   // receiver
   rx_state_t   rx_state_reg;
   logic [TW-1:0] rx_cnt_reg;
   logic [2:0]  rx_bit_reg;
   logic [7:0]  rx_shift_reg;
   logic        rx_done_reg;
   logic [7:0]  rx_byte_reg;

   // a byte is declared at the middle of its stop bit, which lets the
   // answer start before the stop slot is over
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_cnt_reg   <= '0;
         rx_bit_reg   <= '0;
         rx_shift_reg <= '0;
         rx_done_reg  <= 1'b0;
         rx_byte_reg  <= '0;
      end else begin
         rx_done_reg <= 1'b0;
         if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
         end
         unique case (rx_state_reg)
            RX_IDLE: begin
               if (!rx_level_reg) begin
                  rx_state_reg <= RX_START;
                  rx_cnt_reg   <= HALF_LAST;
               end
            end
            RX_START: begin
               if (rx_cnt_reg == '0) begin
                  // a glitch shorter than half a bit is dropped
                  rx_state_reg <= rx_level_reg ? RX_IDLE : RX_DATA;
                  rx_cnt_reg   <= BIT_LAST;
                  rx_bit_reg   <= '0;
               end
            end
            RX_DATA: begin
               if (rx_cnt_reg == '0) begin
                  rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
                  rx_bit_reg   <= rx_bit_reg + 1'b1;
                  rx_cnt_reg   <= BIT_LAST;
                  if (rx_bit_reg == 3'h7) begin
                     rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_cnt_reg == '0) begin
                  rx_state_reg <= RX_IDLE;
                  rx_done_reg  <= rx_level_reg; // framing error: dropped
                  rx_byte_reg  <= rx_shift_reg;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // transmitter
   logic [9:0]    tx_shift_reg;
   logic [TW-1:0] tx_cnt_reg;
   logic [3:0]    tx_bits_reg;
   logic          tx_busy_reg;
   logic          tx_out_reg;
   logic          tx_go;

   // frame is start bit, eight data bits lsb first, stop bit
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_shift_reg <= {10{LINE_IDLE}};
         tx_cnt_reg   <= '0;
         tx_bits_reg  <= '0;
         tx_busy_reg  <= 1'b0;
         tx_out_reg   <= LINE_IDLE;
      end else if (tx_go) begin
         tx_shift_reg <= {LINE_IDLE, ID_BYTE, 1'b0};
         tx_out_reg   <= 1'b0;
         tx_cnt_reg   <= BIT_LAST;
         tx_bits_reg  <= 4'h9;
         tx_busy_reg  <= 1'b1;
      end else if (tx_busy_reg) begin
         if (tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
         end else if (tx_bits_reg == 4'h0) begin
            tx_busy_reg <= 1'b0;
            tx_out_reg  <= LINE_IDLE;
         end else begin
            tx_shift_reg <= {LINE_IDLE, tx_shift_reg[9:1]};
            tx_out_reg   <= tx_shift_reg[1];
            tx_bits_reg  <= tx_bits_reg - 1'b1;
            tx_cnt_reg   <= BIT_LAST;
         end
      end
   end

   assign tx_out = tx_out_reg;

   // ==========================================================
   // loader sequence
   ld_state_t  state_reg;
   logic       sw_reg;
   logic [5:0] in_cnt_reg;
   logic       overrun_reg;
   logic       exec_start_reg;
   logic       opened;
   logic       id_push;
   logic       rx_take;
   logic       push_valid;
   logic       push_ready;
   logic [12:0] push_data;
   logic [12:0] pop_data;

   // the shared-wire strap is taken while reset is held
   always_ff @(posedge clk) begin
      if (rst) begin
         sw_reg <= single_wire;
      end
   end

   assign opened  = (state_reg == LD_WAIT) && rx_done_reg
                    && (rx_byte_reg == OPEN_BYTE);
   assign tx_go   = opened;
   // own identification byte goes in as code byte zero on a shared wire
   assign id_push = opened && sw_reg;
   // on a shared wire the receiver hears our own echo; anything it
   // completes while we transmit is dropped, the byte is already stored
   assign rx_take = rx_done_reg && (in_cnt_reg != BLOCK_LEN)
                    && !(sw_reg && tx_busy_reg)
                    && ((state_reg == LD_LOAD)
                        || (state_reg == LD_ID && !sw_reg));
   assign push_valid = id_push || rx_take;
   assign push_data  = id_push ? {FIRST_IDX, ID_BYTE}
                               : {in_cnt_reg[4:0], rx_byte_reg};

   // state steps: open, identify, load, run
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= LD_WAIT;
      end else begin
         unique case (state_reg)
            LD_WAIT: if (opened) state_reg <= LD_ID;
            LD_ID:   if (tx_busy_reg && tx_cnt_reg == '0
                         && tx_bits_reg == 4'h0) state_reg <= LD_LOAD;
            LD_LOAD: if (code_valid && code_ready
                         && code_index == LAST_IDX) begin
                        state_reg <= LD_RUN;
                     end
            LD_RUN:  state_reg <= LD_RUN;
         endcase
      end
   end

   // counts words put into the buffer, limits the block to its length
   always_ff @(posedge clk) begin
      if (rst) begin
         in_cnt_reg <= CNT_ZERO;
      end else if (push_valid && push_ready) begin
         in_cnt_reg <= in_cnt_reg + 1'b1;
      end
   end

   // a full buffer cannot refuse the line, so the loss is flagged
   always_ff @(posedge clk) begin
      if (rst) begin
         overrun_reg <= 1'b0;
      end else if (push_valid && !push_ready) begin
         overrun_reg <= 1'b1;
      end
   end

   // hand-over pulse once the last byte has left the buffer
   always_ff @(posedge clk) begin
      if (rst) begin
         exec_start_reg <= 1'b0;
      end else begin
         exec_start_reg <= (state_reg == LD_LOAD) && code_valid
                           && code_ready && code_index == LAST_IDX;
      end
   end

   pair_fifo #(
      .WIDTH (13),
      .DEPTH (2)
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (code_valid),
      .out_ready (code_ready),
      .out_data  (pop_data)
   );

   assign code_data  = pop_data[7:0];
   assign code_index = pop_data[12:8];
   assign exec_start = exec_start_reg;
   assign loading    = (state_reg != LD_WAIT) && (state_reg != LD_RUN);
   assign overrun    = overrun_reg;

   // ==========================================================
   // checks
   property p_id_reply;
      @(posedge clk) disable iff (rst)
      (state_reg == LD_WAIT && rx_done_reg && rx_byte_reg == OPEN_BYTE)
      |=> tx_busy_reg && tx_shift_reg[8:1] == ID_BYTE;
   endproperty
   a_id_reply: assert property (p_id_reply)
      else $error("identification byte not sent after opening byte");

   property p_block_limit;
      @(posedge clk) disable iff (rst)
      (in_cnt_reg == BLOCK_LEN) |-> !push_valid ##1 in_cnt_reg == BLOCK_LEN;
   endproperty
   a_block_limit: assert property (p_block_limit)
      else $error("more than one block of code bytes accepted");

   property p_echo_first;
      @(posedge clk) disable iff (rst)
      (opened && sw_reg) |=> code_valid && code_data == ID_BYTE
                             && code_index == FIRST_IDX;
   endproperty
   a_echo_first: assert property (p_echo_first)
      else $error("identification byte not stored as first code byte");

   property p_overlap;
      @(posedge clk) disable iff (rst)
      (rx_done_reg && state_reg == LD_WAIT && rx_byte_reg == OPEN_BYTE)
      |=> !tx_out_reg [*2];
   endproperty
   a_overlap: assert property (p_overlap)
      else $error("start bit not driven inside the stop slot");

   property p_exec;
      @(posedge clk) disable iff (rst)
      (state_reg == LD_LOAD && code_valid && code_ready
       && code_index == LAST_IDX)
      |=> exec_start_reg && state_reg == LD_RUN ##1 !exec_start_reg;
   endproperty
   a_exec: assert property (p_exec)
      else $error("execution not started after last code byte");

   property p_no_early_exec;
      @(posedge clk) disable iff (rst)
      exec_start_reg |-> $past(in_cnt_reg) == BLOCK_LEN;
   endproperty
   a_no_early_exec: assert property (p_no_early_exec)
      else $error("execution started before block complete");
endmodule // boot_loader

// File: verif/uart_host.sv
// behavioural host program at the far end of the loader's serial line
`timescale 1ns/1ns
module uart_host #(
   parameter int BIT_CYCLES_P = 16 // clocks per serial bit
) (
   input  wire logic clk,     // system clock
   input  wire logic line_in, // line as the host hears it
   output      logic line_out // host transmit drive, idle high
);
   logic [7:0] rx_last; // last byte heard
   int         rx_cnt;  // bytes heard so far

   // ==========================================================
   // transmit: 8N1, lsb first, bits change at falling edges
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out = frame[i];
         repeat (BIT_CYCLES_P) @(negedge clk);
      end
   endtask

   // ==========================================================
   // receive: value only recorded, never judged, since the id may be corrupt
   initial begin
      line_out = 1'b1;
      rx_cnt   = 0;
      rx_last  = 8'h00;
      forever begin
         @(posedge clk iff line_in === 1'b0);
         repeat (BIT_CYCLES_P / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES_P) @(posedge clk);
            rx_last[i] = line_in;
         end
         repeat (BIT_CYCLES_P) @(posedge clk);
         rx_cnt++;
      end
   end
endmodule // uart_host

// File: verif/boot_loader_bench.sv
// self-checking bench for the serial boot loader
`timescale 1ns/1ns
module boot_loader_bench;
   import boot_pkg::*;
   localparam int B     = 16;    // shortened bit time keeps the run short
   localparam int LIMIT = 40000; // cycle ceiling for the whole run
   localparam logic [23:0] SEC_START = 24'he00020; // secondary loader base

   logic        clk, rst, single_wire, code_ready, ready_en;
   logic        tx_out, code_valid, exec_start, loading, overrun;
   logic        rx_pin, host_in, host_out;
   logic [7:0]  code_data;
   logic [4:0]  code_index;
   logic [12:0] got_q[$];
   logic [12:0] exp_q[$];
   int          error_cnt, checks_done, cyc, last_take, exec_cnt, exec_gap;

   boot_loader #(.BIT_CYCLES_P(B)) DUT (
      .clk(clk), .rst(rst), .rx_pin(rx_pin), .tx_out(tx_out),
      .single_wire(single_wire), .code_valid(code_valid),
      .code_ready(code_ready), .code_data(code_data),
      .code_index(code_index), .exec_start(exec_start),
      .loading(loading), .overrun(overrun));

   uart_host #(.BIT_CYCLES_P(B)) HOST (
      .clk(clk), .line_in(host_in), .line_out(host_out));

   // shared wire is a wired and of both senders; duplex keeps them apart
   assign rx_pin  = single_wire ? (host_out & tx_out) : host_out;
   assign host_in = single_wire ? (host_out & tx_out) : tx_out;

   // clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // random stalls from the program store, applied at falling edges
   always @(negedge clk) begin
      code_ready = ready_en & (($urandom() % 2) == 1);
   end

   // collect taken words, time the start pulse, cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (exec_start === 1'b1) begin
         exec_cnt++;
         exec_gap = cyc - last_take;
      end
      if (code_valid === 1'b1 && code_ready === 1'b1) begin
         got_q.push_back({code_index, code_data});
         last_take = cyc;
      end
      if (cyc >= LIMIT) begin
         error_cnt++;
         print_verdict();
      end
   end

   // ==========================================================
   // helpers
   task automatic chk(input string name, input logic [12:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [12:0] word(input int idx, input logic [7:0] d);
      return {5'(idx), d};
   endfunction

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic do_reset(input logic sw);
      @(negedge clk);
      rst = 1'b1;
      single_wire = sw;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      got_q.delete();
      exp_q.delete();
      exec_cnt = 0;
   endtask

   task automatic cmp_stream();
      chk("stream length", 13'(got_q.size()), 13'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < got_q.size()) begin
            chk("code word", got_q[i], exp_q[i]);
         end
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic run_block(input logic sw);
      logic [7:0] b;
      logic [7:0] fill[3];
      int         n;
      fill = '{8'h8e, 8'h1e, 8'hff};
      do_reset(sw);
      ready_en = 1'b1;
      HOST.send_byte(8'h33);
      chk("loading after nonzero", 13'(loading), 13'h0);
      HOST.send_byte(OPEN_BYTE);
      chk("tx in host stop bit", 13'(tx_out), 13'h0);
      chk("loading after open", 13'(loading), 13'h1);
      n = sw ? CODE_BYTES - 1 : CODE_BYTES;
      // on a shared wire the host waits for the echo to pass
      if (sw) begin
         exp_q.push_back(word(0, ID_BYTE));
         repeat (10 * B) @(negedge clk);
      end
      for (int i = 0; i < n; i++) begin
         b = (sw && i < 3) ? fill[i] : 8'($urandom);
         // shortened secondary loader image names its own start address
         if (sw && i >= 3 && i < 6) begin
            b = SEC_START[8*(i-3) +: 8];
         end
         exp_q.push_back(word(exp_q.size(), b));
         HOST.send_byte(b);
      end
      for (int i = 0; i < 40 * B && exec_cnt == 0; i++) begin
         @(negedge clk);
      end
      if (!sw) begin
         chk("id byte", 13'(HOST.rx_last), 13'(ID_BYTE));
      end
      // a late byte must be ignored once running
      HOST.send_byte(8'h77);
      repeat (2 * B) @(negedge clk);
      cmp_stream();
      chk("exec pulses", 13'(exec_cnt), 13'h1);
      chk("exec delay", 13'(exec_gap), 13'h1);
      chk("loading after run", 13'(loading), 13'h0);
   endtask

   task automatic run_overrun();
      do_reset(1'b0);
      ready_en = 1'b0;
      HOST.send_byte(OPEN_BYTE);
      for (int i = 0; i < 3; i++) begin
         HOST.send_byte(8'ha0 + 8'(i));
      end
      repeat (B) @(negedge clk);
      chk("overrun flag", 13'(overrun), 13'h1);
      chk("valid while stalled", 13'(code_valid), 13'h1);
      ready_en = 1'b1;
      // random stalls need room: two takes are not sure within a few cycles
      repeat (4 * B) @(negedge clk);
      exp_q = '{word(0, 8'ha0), word(1, 8'ha1)};
      cmp_stream();
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst         = 1'b1;
      single_wire = 1'b0;
      code_ready  = 1'b0;
      ready_en    = 1'b0;
      error_cnt   = 0;
      checks_done = 0;
      cyc         = 0;
      last_take   = 0;
      exec_cnt    = 0;
      exec_gap    = 0;
      void'($urandom(2990));
      run_block(1'b0);
      run_block(1'b1);
      run_overrun();
      print_verdict();
   end
endmodule // boot_loader_bench
